// File: inc/cts_pkg.sv
// Constants shared by the clock and timestamp configuration register group.
package cts_pkg;

  // Serial frame: one direction bit, fifteen address bits, eight data bits.
  localparam int unsigned CMD_BITS  = 16;
  localparam int unsigned ADDR_BITS = 15;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned FRAME_BITS = CMD_BITS + DATA_BITS;
  localparam int unsigned CNT_W     = 5;
  localparam logic        DIR_READ  = 1'b1;

  // Pin synchroniser depth and clock figures.
  localparam int unsigned SYNC_STAGES  = 2;
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Register offsets.
  localparam int unsigned NUM_REGS = 6;
  localparam logic [14:0] OFS_STAMP_CTRL = 15'h003b;
  localparam logic [14:0] OFS_REFOUT_CTRL = 15'h003c;
  localparam logic [14:0] OFS_FBDIV_VP = 15'h003d;
  localparam logic [14:0] OFS_FBDIV_N = 15'h003e;
  localparam logic [14:0] OFS_OSC_BIAS = 15'h003f;
  localparam logic [14:0] OFS_LANE_EMPH = 15'h0048;

  // Register indices inside the bank.
  localparam logic [2:0] IDX_STAMP_CTRL = 3'h0;
  localparam logic [2:0] IDX_REFOUT_CTRL = 3'h1;
  localparam logic [2:0] IDX_FBDIV_VP = 3'h2;
  localparam logic [2:0] IDX_FBDIV_N = 3'h3;
  localparam logic [2:0] IDX_OSC_BIAS = 3'h4;
  localparam logic [2:0] IDX_LANE_EMPH = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // Reset values.
  localparam logic [7:0] RST_STAMP_CTRL = 8'h00;
  localparam logic [7:0] RST_REFOUT_CTRL = 8'h01;
  localparam logic [7:0] RST_FBDIV_VP = 8'h00;
  localparam logic [7:0] RST_FBDIV_N = 8'h20;
  localparam logic [7:0] RST_OSC_BIAS = 8'h4f;
  localparam logic [7:0] RST_LANE_EMPH = 8'h00;

  // Field positions.
  localparam int unsigned POS_STAMP_RECV = 0;
  localparam int unsigned POS_STAMP_LVMODE = 1;
  localparam int unsigned POS_REFOUT_EN = 0;
  localparam int unsigned POS_V_DIV_LSB = 0;
  localparam int unsigned POS_P_DIV_LSB = 2;
  localparam int unsigned DIV_CODE_W = 2;
  localparam int unsigned N_DIV_W = 6;
  localparam int unsigned BIAS_W = 7;
  localparam int unsigned EMPH_W = 4;
  localparam int unsigned RATIO_W = 3;

  // Divider codes.
  localparam logic [1:0] CODE_RSVD = 2'h3;

  typedef enum logic [1:0] {
    CTS_IDLE = 2'b00,
    CTS_CMD  = 2'b01,
    CTS_DATA = 2'b11,
    CTS_DONE = 2'b10
  } cts_state_e;

endpackage

// File: rtl/cts_cfg_reg.sv
// One eight-bit read/write configuration register with its own reset value.
`timescale 1ns/10ps
`default_nettype none
module cts_cfg_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       clk,     // System clock.
  input  wire logic       rst_n,   // Synchronous reset, active low.
  input  wire logic       wr_en,   // One-cycle write strobe.
  input  wire logic [7:0] wr_data, // Byte to store.
  output logic      [7:0] q        // Stored byte.
);

  logic [7:0] value_ff;

  // Every bit is stored, reserved ones too, so a read gives back what was written.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      value_ff <= RESET_VAL;
    else if (wr_en)
      value_ff <= wr_data;
  end

  assign q = value_ff;

endmodule // cts_cfg_reg
`default_nettype wire

// File: rtl/cts_clock_stamp_regs.sv
// Clock, timestamp and lane emphasis configuration registers behind the serial port.
//
// Behaviour
// RULE1 - Stamp control bit 0 enables the differential timestamp receiver.
// RULE2 - Stamp control bit 1 selects low-voltage input mode and drops self-biasing.
// RULE3 - Reference output runs while its enable bit and the loop enable are set.
// RULE4 - Bits 3:2 pick the second divider: 1, 2, 4, code 3 reserved.
// RULE5 - Bits 1:0 pick the first divider: 5, 4, 3, code 3 reserved.
// RULE6 - Third divider takes its six-bit value 1 to 63, reset 32.
// RULE7 - Host holds loop reset asserted while changing any feedback divider.
// RULE8 - Host writes oscillator bias 0x4A when using the internal loop.
// RULE9 - One four-bit emphasis value drives every serial lane together.
// RULE10 - Host writes reserved bits with their default of zero.
// RULE11 - Reads return the last written value, or the reset value.
`timescale 1ns/10ps
`default_nettype none
module cts_clock_stamp_regs #(
  parameter int unsigned LANES = 8
) (
  input  wire logic                       clk,                          // System clock.
  input  wire logic                       rst_n,                        // Sync reset, low.
  input  wire logic                       spi_sclk,                     // Serial clock pin.
  input  wire logic                       spi_cs_n,                     // Chip select pin, low.
  input  wire logic                       spi_sdi,                      // Serial data in pin.
  output logic                            spi_sdo,                      // Serial data out.
  output logic                            spi_sdo_oe,                   // Drive enable of sdo.
  input  wire logic                       pll_enable,                   // Loop enable pin.
  input  wire logic                       loop_reset_control,           // Loop reset level.
  output logic                            stamp_receiver_enable,        // Receiver on.
  output logic                            stamp_low_voltage_input_mode, // Low-voltage mode.
  output logic                            stamp_self_bias_enable,       // Common-mode bias on.
  output logic                            reference_output_enable,      // Reference out on.
  output logic [cts_pkg::RATIO_W-1:0]     first_div_ratio,              // 5, 4, 3 or 0.
  output logic [cts_pkg::RATIO_W-1:0]     second_div_ratio,             // 1, 2, 4 or 0.
  output logic [cts_pkg::N_DIV_W-1:0]     third_div_ratio,              // 0 to 63; 0 invalid.
  output logic                            divider_setting_valid,        // No reserved code, third not 0.
  output logic                            divider_write_unguarded,      // Pulse, see below.
  output logic [cts_pkg::BIAS_W-1:0]      oscillator_bias_level,        // Oscillator bias.
  output logic [LANES*cts_pkg::EMPH_W-1:0] lane_emphasis_level         // Per-lane copies.
);

  if (LANES < 1 || LANES > 8)
  begin : g_lanes_check
    $error("LANES must lie between 1 and 8");
  end

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic [2:0] reg_index(input logic [cts_pkg::ADDR_BITS-1:0] addr);
    logic [2:0] idx;
    idx = cts_pkg::IDX_NONE;
    unique case (addr)
      cts_pkg::OFS_STAMP_CTRL:  idx = cts_pkg::IDX_STAMP_CTRL;
      cts_pkg::OFS_REFOUT_CTRL: idx = cts_pkg::IDX_REFOUT_CTRL;
      cts_pkg::OFS_FBDIV_VP:    idx = cts_pkg::IDX_FBDIV_VP;
      cts_pkg::OFS_FBDIV_N:     idx = cts_pkg::IDX_FBDIV_N;
      cts_pkg::OFS_OSC_BIAS:    idx = cts_pkg::IDX_OSC_BIAS;
      cts_pkg::OFS_LANE_EMPH:   idx = cts_pkg::IDX_LANE_EMPH;
      default:                  idx = cts_pkg::IDX_NONE;
    endcase
    return idx;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection.

  logic [3:0] pins_s;
  logic       sclk_s;
  logic       cs_n_s;
  logic       sdi_s;
  logic       pll_en_s;
  logic       sclk_prev_ff;
  logic       sclk_rise;

  cts_sync #(
    .WIDTH     (4),
    .RESET_VAL (4'h4)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   ({pll_enable, spi_cs_n, spi_sdi, spi_sclk}),
    .sync_out (pins_s)
  );

  assign sclk_s   = pins_s[0];
  assign sdi_s    = pins_s[1];
  assign cs_n_s   = pins_s[2];
  assign pll_en_s = pins_s[3];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sclk_prev_ff <= 1'b0;
    else
      sclk_prev_ff <= sclk_s;
  end

  assign sclk_rise = sclk_s & ~sclk_prev_ff & ~cs_n_s;

  //////////////////////////////////////////////////////////////////////////////
  // Serial frame sequencing.

  cts_pkg::cts_state_e            state_ff;
  logic [cts_pkg::CNT_W-1:0]      bit_cnt_ff;
  logic [cts_pkg::CMD_BITS-1:0]   cmd_sr_ff;
  logic [cts_pkg::DATA_BITS-1:0]  wr_sr_ff;
  logic [cts_pkg::DATA_BITS-1:0]  rd_sr_ff;
  logic [2:0]                     idx_ff;
  logic                           is_read_ff;
  logic                           wr_pulse_ff;
  logic [cts_pkg::DATA_BITS-1:0]  reg_q [cts_pkg::NUM_REGS];
  logic [cts_pkg::CMD_BITS-1:0]   nxt_cmd;
  logic [cts_pkg::DATA_BITS-1:0]  nxt_wr;
  logic [cts_pkg::DATA_BITS-1:0]  rd_value;
  logic [2:0]                     nxt_idx;
  logic                           cmd_last;
  logic                           data_last;

  assign nxt_cmd   = {cmd_sr_ff[cts_pkg::CMD_BITS-2:0], sdi_s};
  assign nxt_wr    = {wr_sr_ff[cts_pkg::DATA_BITS-2:0], sdi_s};
  assign nxt_idx   = reg_index(nxt_cmd[cts_pkg::ADDR_BITS-1:0]);
  assign cmd_last  = (bit_cnt_ff == cts_pkg::CNT_W'(cts_pkg::CMD_BITS - 1));
  assign data_last = (bit_cnt_ff == cts_pkg::CNT_W'(cts_pkg::FRAME_BITS - 1));
  // Unmapped offsets read as zero and swallow writes.
  assign rd_value  = (nxt_idx == cts_pkg::IDX_NONE) ? 8'h00 : reg_q[nxt_idx]; // see RULE11

  always_ff @(posedge clk)
  begin
    if (!rst_n || cs_n_s)
    begin
      state_ff   <= cts_pkg::CTS_IDLE;
      bit_cnt_ff <= '0;
    end
    else if (sclk_rise)
    begin
      bit_cnt_ff <= bit_cnt_ff + cts_pkg::CNT_W'(1);
      unique case (state_ff)
        cts_pkg::CTS_IDLE: state_ff <= cts_pkg::CTS_CMD;
        cts_pkg::CTS_CMD:  state_ff <= cmd_last ? cts_pkg::CTS_DATA : cts_pkg::CTS_CMD;
        cts_pkg::CTS_DATA: state_ff <= data_last ? cts_pkg::CTS_DONE : cts_pkg::CTS_DATA;
        cts_pkg::CTS_DONE: state_ff <= cts_pkg::CTS_DONE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cmd_sr_ff  <= '0;
      wr_sr_ff   <= '0;
      idx_ff     <= cts_pkg::IDX_NONE;
      is_read_ff <= 1'b0;
    end
    else if (sclk_rise && state_ff != cts_pkg::CTS_DONE)
    begin
      if (state_ff != cts_pkg::CTS_DATA)
        cmd_sr_ff <= nxt_cmd;
      else
        wr_sr_ff <= nxt_wr;
      if (state_ff == cts_pkg::CTS_CMD && cmd_last)
      begin
        idx_ff     <= nxt_idx;
        is_read_ff <= (nxt_cmd[cts_pkg::CMD_BITS-1] == cts_pkg::DIR_READ);
      end
    end
  end

  // The read byte is loaded as the last command bit arrives, so its first bit
  // is on sdo before the host's next rising edge.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rd_sr_ff <= '0;
    else if (sclk_rise && state_ff == cts_pkg::CTS_CMD && cmd_last)
      rd_sr_ff <= rd_value; // see RULE11
    else if (sclk_rise && state_ff == cts_pkg::CTS_DATA)
      rd_sr_ff <= {rd_sr_ff[cts_pkg::DATA_BITS-2:0], 1'b0};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wr_pulse_ff <= 1'b0;
    else
      wr_pulse_ff <= sclk_rise && state_ff == cts_pkg::CTS_DATA && data_last
                     && !is_read_ff && idx_ff != cts_pkg::IDX_NONE;
  end

  assign spi_sdo    = rd_sr_ff[cts_pkg::DATA_BITS-1];
  assign spi_sdo_oe = is_read_ff && state_ff == cts_pkg::CTS_DATA;

  //////////////////////////////////////////////////////////////////////////////
  // Register bank. Reserved bits are stored as written; the host keeps them
  // at zero, and nothing below looks at them.

  localparam logic [7:0] RST_VALS [cts_pkg::NUM_REGS] = '{
    cts_pkg::RST_STAMP_CTRL, cts_pkg::RST_REFOUT_CTRL, cts_pkg::RST_FBDIV_VP,
    cts_pkg::RST_FBDIV_N, cts_pkg::RST_OSC_BIAS, cts_pkg::RST_LANE_EMPH};

  for (genvar i = 0; i < cts_pkg::NUM_REGS; i++)
  begin : g_regs
    cts_cfg_reg #(
      .RESET_VAL (RST_VALS[i])
    ) u_reg (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (wr_pulse_ff && idx_ff == 3'(i)),  // see RULE11
      .wr_data (wr_sr_ff),
      .q       (reg_q[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded control levels, all registered.

  logic [1:0]                    v_code;
  logic [1:0]                    p_code;
  logic [cts_pkg::N_DIV_W-1:0]   n_val;
  logic [cts_pkg::EMPH_W-1:0]    emph_ff;
  logic                          recv_ff;
  logic                          lvmode_ff;
  logic                          refout_ff;
  logic [cts_pkg::RATIO_W-1:0]   v_ratio_ff;
  logic [cts_pkg::RATIO_W-1:0]   p_ratio_ff;
  logic [cts_pkg::N_DIV_W-1:0]   n_ratio_ff;
  logic                          div_ok_ff;
  logic                          unguarded_ff;
  logic [cts_pkg::BIAS_W-1:0]    bias_ff;

  assign v_code = reg_q[cts_pkg::IDX_FBDIV_VP][cts_pkg::POS_V_DIV_LSB +: cts_pkg::DIV_CODE_W];
  assign p_code = reg_q[cts_pkg::IDX_FBDIV_VP][cts_pkg::POS_P_DIV_LSB +: cts_pkg::DIV_CODE_W];
  assign n_val  = reg_q[cts_pkg::IDX_FBDIV_N][cts_pkg::N_DIV_W-1:0];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      recv_ff   <= 1'b0;
      lvmode_ff <= 1'b0;
      refout_ff <= 1'b0;
    end
    else
    begin
      recv_ff   <= reg_q[cts_pkg::IDX_STAMP_CTRL][cts_pkg::POS_STAMP_RECV];   // see RULE1
      lvmode_ff <= reg_q[cts_pkg::IDX_STAMP_CTRL][cts_pkg::POS_STAMP_LVMODE]; // see RULE2
      refout_ff <= reg_q[cts_pkg::IDX_REFOUT_CTRL][cts_pkg::POS_REFOUT_EN]
                   & pll_en_s;                                              // see RULE3
    end
  end

  // Reserved codes give a ratio of zero, which the loop treats as stopped.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      v_ratio_ff <= 3'h5;
      p_ratio_ff <= 3'h1;
      n_ratio_ff <= cts_pkg::RST_FBDIV_N[cts_pkg::N_DIV_W-1:0];
      div_ok_ff  <= 1'b1;
    end
    else
    begin
      unique case (v_code)                                                  // see RULE5
        2'h0:    v_ratio_ff <= 3'h5;
        2'h1:    v_ratio_ff <= 3'h4;
        2'h2:    v_ratio_ff <= 3'h3;
        2'h3:    v_ratio_ff <= 3'h0;
      endcase
      unique case (p_code)                                                  // see RULE4
        2'h0:    p_ratio_ff <= 3'h1;
        2'h1:    p_ratio_ff <= 3'h2;
        2'h2:    p_ratio_ff <= 3'h4;
        2'h3:    p_ratio_ff <= 3'h0;
      endcase
      n_ratio_ff <= n_val;                                                  // see RULE6
      div_ok_ff  <= v_code != cts_pkg::CODE_RSVD && p_code != cts_pkg::CODE_RSVD
                    && n_val != '0;                                         // see RULE6
    end
  end

  // The write is still taken; the pulse only tells the loop logic that the
  // host changed a divider without holding the loop in reset.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      unguarded_ff <= 1'b0;
    else
      unguarded_ff <= wr_pulse_ff && !loop_reset_control
                      && (idx_ff == cts_pkg::IDX_FBDIV_VP
                          || idx_ff == cts_pkg::IDX_FBDIV_N);               // see RULE7
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bias_ff <= cts_pkg::RST_OSC_BIAS[cts_pkg::BIAS_W-1:0];
      emph_ff <= cts_pkg::RST_LANE_EMPH[cts_pkg::EMPH_W-1:0];
    end
    else
    begin
      bias_ff <= reg_q[cts_pkg::IDX_OSC_BIAS][cts_pkg::BIAS_W-1:0];          // see RULE8
      emph_ff <= reg_q[cts_pkg::IDX_LANE_EMPH][cts_pkg::EMPH_W-1:0];         // see RULE9
    end
  end

  for (genvar l = 0; l < LANES; l++)
  begin : g_lanes
    assign lane_emphasis_level[l*cts_pkg::EMPH_W +: cts_pkg::EMPH_W] = emph_ff; // see RULE9
  end

  assign stamp_receiver_enable        = recv_ff;
  assign stamp_low_voltage_input_mode = lvmode_ff;
  assign stamp_self_bias_enable       = ~lvmode_ff;  // see RULE2
  assign reference_output_enable      = refout_ff;
  assign first_div_ratio              = v_ratio_ff;
  assign second_div_ratio             = p_ratio_ff;
  assign third_div_ratio              = n_ratio_ff;
  assign divider_setting_valid        = div_ok_ff;
  assign divider_write_unguarded      = unguarded_ff;
  assign oscillator_bias_level        = bias_ff;

endmodule // cts_clock_stamp_regs
`default_nettype wire

// File: rtl/cts_sync.sv
// Two-stage synchroniser for pins entering the clock domain.
`timescale 1ns/10ps
`default_nettype none
module cts_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,      // System clock.
  input  wire logic             rst_n,    // Synchronous reset, active low.
  input  wire logic [WIDTH-1:0] pin_in,   // Asynchronous pin levels.
  output logic      [WIDTH-1:0] sync_out  // Levels safe to use in clk domain.
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // cts_sync
`default_nettype wire

// File: verification/cts_clock_stamp_regs_bench.sv
// Self-checking bench for the clock and timestamp register group.
`timescale 1ns/10ps
`default_nettype none
module cts_clock_stamp_regs_bench;
  localparam int unsigned LANES = 8;
  logic             clk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, pll_en, lrc;
  logic             recv, lvm, sbias, refo, valid, ung;
  logic [2:0]       r1, r2;
  logic [5:0]       r3;
  logic [6:0]       bias;
  logic [7:0]       cut_q;
  logic [LANES*4-1:0] emph;
  logic [14:0]      ofs [6];
  logic [7:0]       rst_val [6];
  logic [2:0]       v_tab [4];
  logic [2:0]       p_tab [4];
  logic [5:0]       n_tab [3];
  int               failures, total_checks, cycles, ung_cnt;

  cts_spi_host host (.clk(clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
  cts_clock_stamp_regs #(.LANES(LANES)) uut (
    .clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
    .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .pll_enable(pll_en), .loop_reset_control(lrc),
    .stamp_receiver_enable(recv), .stamp_low_voltage_input_mode(lvm),
    .stamp_self_bias_enable(sbias), .reference_output_enable(refo),
    .first_div_ratio(r1), .second_div_ratio(r2), .third_div_ratio(r3),
    .divider_setting_valid(valid), .divider_write_unguarded(ung),
    .oscillator_bias_level(bias), .lane_emphasis_level(emph));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(~cts_pkg::DIR_READ, a, d, 24, q);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(cts_pkg::DIR_READ, a, 8'h00, 24, q);
    chk(32'(q), 32'(e));
  endtask

  // A hang would leave the verdict unprinted, so the cycle count is capped.
  always @(posedge clk)
  begin
    cycles++;
    if (ung === 1'b1)
      ung_cnt++;
    if (cycles == 40000)
    begin
      failures++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ofs = '{cts_pkg::OFS_STAMP_CTRL, cts_pkg::OFS_REFOUT_CTRL, cts_pkg::OFS_FBDIV_VP,
            cts_pkg::OFS_FBDIV_N, cts_pkg::OFS_OSC_BIAS, cts_pkg::OFS_LANE_EMPH};
    rst_val = '{8'h00, 8'h01, 8'h00, 8'h20, 8'h4f, 8'h00};
    v_tab = '{3'h5, 3'h4, 3'h3, 3'h0};
    p_tab = '{3'h1, 3'h2, 3'h4, 3'h0};
    n_tab = '{6'h01, 6'h3f, 6'h00};
    rst_n = 1'b0;
    pll_en = 1'b1;
    lrc = 1'b1;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    for (int i = 0; i < 6; i++)
      rd_chk(ofs[i], rst_val[i]);
    chk(32'(refo), 32'h1);
    chk(32'(r3), 32'h20);
    $display("test reset_values done");

    wr(cts_pkg::OFS_STAMP_CTRL, 8'h01);
    chk(32'(recv), 32'h1);
    chk(32'(sbias), 32'h1);
    wr(cts_pkg::OFS_STAMP_CTRL, 8'h02);
    chk(32'(recv), 32'h0);
    chk(32'({lvm, sbias}), 32'h2);
    rd_chk(cts_pkg::OFS_STAMP_CTRL, 8'h02);
    $display("test stamp_control done");

    for (int i = 0; i < 4; i++)
    begin
      wr(cts_pkg::OFS_FBDIV_VP, 8'((i << 2) | i));
      chk(32'(r1), 32'(v_tab[i]));
      chk(32'(r2), 32'(p_tab[i]));
      chk(32'(valid), 32'(i != 3));
    end
    wr(cts_pkg::OFS_FBDIV_VP, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(cts_pkg::OFS_FBDIV_N, 8'(n_tab[i]));
      chk(32'(r3), 32'(n_tab[i]));
      chk(32'(valid), 32'(i != 2));
    end
    chk(32'(ung_cnt), 32'h0);
    $display("test dividers done");

    lrc = 1'b0;
    wr(cts_pkg::OFS_FBDIV_N, 8'h20);
    chk(32'(ung_cnt), 32'h1);
    wr(cts_pkg::OFS_STAMP_CTRL, 8'h00);
    chk(32'(ung_cnt), 32'h1);
    lrc = 1'b1;
    rd_chk(cts_pkg::OFS_FBDIV_N, 8'h20);
    $display("test unguarded_write done");

    wr(cts_pkg::OFS_OSC_BIAS, 8'h4a);
    chk(32'(bias), 32'h4a);
    wr(cts_pkg::OFS_LANE_EMPH, 8'h0b);
    chk(32'(emph), 32'({LANES{4'hb}}));
    wr(cts_pkg::OFS_LANE_EMPH, 8'h05);
    chk(32'(emph), 32'({LANES{4'h5}}));
    $display("test bias_emphasis done");

    wr(cts_pkg::OFS_REFOUT_CTRL, 8'h00);
    chk(32'(refo), 32'h0);
    wr(cts_pkg::OFS_REFOUT_CTRL, 8'h01);
    chk(32'(refo), 32'h1);
    pll_en = 1'b0;
    repeat (6) @(negedge clk);
    chk(32'(refo), 32'h0);
    pll_en = 1'b1;
    repeat (6) @(negedge clk);
    chk(32'(refo), 32'h1);
    $display("test reference_output done");

    wr(15'h0040, 8'h5a);
    rd_chk(15'h0040, 8'h00);
    rd_chk(cts_pkg::OFS_OSC_BIAS, 8'h4a);
    rd_chk(cts_pkg::OFS_LANE_EMPH, 8'h05);
    host.xfer(~cts_pkg::DIR_READ, cts_pkg::OFS_LANE_EMPH, 8'hff, 20, cut_q);
    rd_chk(cts_pkg::OFS_LANE_EMPH, 8'h05);
    $display("test unmapped done");
    close_out();
  end
endmodule // cts_clock_stamp_regs_bench

bind cts_clock_stamp_regs cts_clock_stamp_regs_chk #(.LANES(LANES)) chk (
  .clk(clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
  .pll_enable(pll_enable), .loop_reset_control(loop_reset_control),
  .stamp_low_voltage_input_mode(stamp_low_voltage_input_mode),
  .stamp_self_bias_enable(stamp_self_bias_enable),
  .reference_output_enable(reference_output_enable), .first_div_ratio(first_div_ratio),
  .second_div_ratio(second_div_ratio), .third_div_ratio(third_div_ratio),
  .divider_setting_valid(divider_setting_valid),
  .divider_write_unguarded(divider_write_unguarded),
  .lane_emphasis_level(lane_emphasis_level));
`default_nettype wire

// File: verification/cts_clock_stamp_regs_chk.sv
// Concurrent checks on the ports of the clock and timestamp register group.
`timescale 1ns/10ps
`default_nettype none
module cts_clock_stamp_regs_chk #(
  parameter int unsigned LANES = 8
) (
  input wire logic                         clk,                          // System clock.
  input wire logic                         rst_n,                        // Sync reset, low.
  input wire logic                         spi_cs_n,                     // Chip select pin.
  input wire logic                         spi_sdo_oe,                   // Drive enable of sdo.
  input wire logic                         pll_enable,                   // Loop enable pin.
  input wire logic                         loop_reset_control,           // Loop reset level.
  input wire logic                         stamp_low_voltage_input_mode, // Low-voltage mode.
  input wire logic                         stamp_self_bias_enable,       // Self-bias on.
  input wire logic                         reference_output_enable,      // Reference out on.
  input wire logic [cts_pkg::RATIO_W-1:0]  first_div_ratio,              // First ratio.
  input wire logic [cts_pkg::RATIO_W-1:0]  second_div_ratio,             // Second ratio.
  input wire logic [cts_pkg::N_DIV_W-1:0]  third_div_ratio,              // Third ratio.
  input wire logic                         divider_setting_valid,        // No reserved code, third not 0.
  input wire logic                         divider_write_unguarded,      // Unguarded write.
  input wire logic [LANES*cts_pkg::EMPH_W-1:0] lane_emphasis_level      // Per-lane copies.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence pll_off_s;
    !pll_enable [*4];
  endsequence
  sequence cs_idle_s;
    spi_cs_n [*4];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  bias_inverse_a: assert property ($stable(stamp_low_voltage_input_mode) [*2]
    |-> stamp_self_bias_enable != stamp_low_voltage_input_mode)
    else $error("self bias not the inverse of low-voltage mode");
  first_ratio_a: assert property (first_div_ratio inside {3'h5, 3'h4, 3'h3, 3'h0})
    else $error("first divider ratio outside its table");
  second_ratio_a: assert property (second_div_ratio inside {3'h1, 3'h2, 3'h4, 3'h0})
    else $error("second divider ratio outside its table");
  valid_match_a: assert property ($stable(first_div_ratio) && $stable(second_div_ratio)
    && $stable(third_div_ratio) |-> divider_setting_valid == (first_div_ratio != 3'h0
    && second_div_ratio != 3'h0 && third_div_ratio != 6'h00))
    else $error("divider valid flag disagrees with ratios");
  refout_off_a: assert property (pll_off_s |-> !reference_output_enable)
    else $error("reference output on while loop disabled");
  refout_rise_a: assert property ($rose(reference_output_enable) |-> $past(pll_enable, 3))
    else $error("reference output rose without loop enable");
  lanes_equal_a: assert property (lane_emphasis_level
    == {LANES{lane_emphasis_level[cts_pkg::EMPH_W-1:0]}})
    else $error("lane emphasis copies differ");
  oe_idle_a: assert property (cs_idle_s |-> !spi_sdo_oe)
    else $error("sdo driven outside a frame");
  oe_start_a: assert property ($rose(spi_sdo_oe) |-> !$past(spi_cs_n, 3))
    else $error("sdo drive began without chip select");
  pulse_single_a: assert property (divider_write_unguarded |=> !divider_write_unguarded)
    else $error("unguarded flag longer than one cycle");
  pulse_cause_a: assert property (divider_write_unguarded |-> !$past(loop_reset_control))
    else $error("unguarded flag with loop reset held");
  unguarded_c: cover property (divider_write_unguarded);
endmodule // cts_clock_stamp_regs_chk
`default_nettype wire

// File: verification/cts_spi_host.sv
// Serial host model that frames register reads and writes for the bench.
`timescale 1ns/10ps
`default_nettype none
module cts_spi_host (
  input  wire logic clk,  // System clock, used only to pace the frames.
  input  wire logic sdo,  // Read data from the device.
  output logic      sclk, // Serial clock, still outside frames.
  output logic      cs_n, // Chip select, low within a frame.
  output logic      sdi   // Serial data to the device.
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // Five clocks a phase leaves margin over the three that synchronising and edge detection take.
  task automatic half();
    repeat (5) @(negedge clk);
  endtask

  // A frame of fewer than 24 bits is cut short; the device must then store nothing.
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                      input int n, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, wd};
    q = 8'h00;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 23; i > 23 - n; i--)
    begin
      sdi = f[i];
      half();
      if (i < 8)
        q = {q[6:0], sdo};
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    // Released data line shows the inverse so a stale bit cannot pass for data.
    sdi = ~sdi;
    repeat (10) @(negedge clk);
  endtask
endmodule // cts_spi_host
`default_nettype wire
